// ---- hw/sfr_bank_pkg.sv ----
// Constants and state layout for the special-function register bank
package sfr_bank_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [3:0] OFS_STATUS = 4'h3;
    localparam logic [3:0] OFS_POINTER = 4'h4;
    localparam logic [3:0] OFS_PORT = 4'h6;
    localparam logic [3:0] OFS_POWER = 4'h8;
    localparam logic [3:0] OFS_WAKE = 4'h9;
    localparam logic [3:0] OFS_PCHI = 4'hA;
    localparam logic [3:0] OFS_PULLDN = 4'hB;
    localparam logic [3:0] OFS_PULLUP = 4'hC;
    localparam logic [3:0] OFS_IRQ_EN = 4'hE;
    localparam logic [3:0] OFS_IRQ_FLAG = 4'hF;

    // ==========================================================
    // Field positions
    localparam int POW_WATCHDOG = 7;
    localparam int POW_EXT_SEL = 6;
    localparam int POW_LOWV_DET = 5;
    localparam int POW_LOWV_RST = 3;
    localparam int POW_COMPARATOR = 2;
    localparam int IRQ_TICK0 = 0;
    localparam int IRQ_PIN_CHANGE = 1;
    localparam int IRQ_EXT = 2;
    localparam int IRQ_TICK1 = 3;
    localparam int IRQ_LOWV = 4;
    localparam int IRQ_WATCHDOG = 6;

    // ==========================================================
    // Reset values and implemented-bit masks
    localparam logic [7:0] POWER_RESET = 8'h88;
    localparam logic [5:0] WAKE_RESET = 6'h3F;
    localparam logic [3:0] PULLDN_RESET = 4'hF;
    localparam logic [5:0] PULLUP_RESET = 6'h3F;
    localparam logic [2:0] PCHI_RESET = 3'h0;
    localparam logic [7:0] POINTER_RESET = 8'h00;
    localparam logic [7:0] IRQ_RESET = 8'h00;
    localparam logic [7:0] IRQ_IMPL_MASK = 8'h5F;
    localparam logic [1:0] BANK_ONLY = 2'h0;
    localparam logic [1:0] SYNC_FILLED = 2'h3;

    // ==========================================================
    // Complete state of the bank
    typedef struct packed {
        logic carry;
        logic half_carry;
        logic zero;
        logic watchdog_expiry_flag_n;
        logic powerdown_flag_n;
        logic [2:0] status_spare;
        logic [7:0] pointer;
        logic [5:0] port_latch;
        logic [1:0] port_spare;
        logic [7:0] power;
        logic [5:0] wake;
        logic [2:0] pc_high;
        logic [3:0] pulldown_off_n;
        logic [5:0] pullup_off_n;
        logic [7:0] irq_en;
        logic [7:0] irq_flag;
        logic [5:0] pin_s1;
        logic [5:0] pin_s2;
        logic [5:0] pin_prev;
        logic [1:0] sync_fill;
        logic [7:0] rd_data;
        logic irq_req;
        logic wake_req;
    } bank_state_t;

endpackage : sfr_bank_pkg

// ---- hw/core_sfr_status_port_irq_bank.sv ----
// Directly addressed special-function register bank of the core
// ==========================================================
// Overview of operation
// - Carry set on add carry or no borrow
// - Half-carry from low nibble, same sense
// - Zero flag follows logical result equals zero
// - Power-down flag high at reset, low on sleep
// - Time-out flag high on reset/clear/sleep, low on expiry
// - Spare bits are plain storage, status spares reset zero
// - Pointer low six bits select one of 64
// - Port read gives pins, or latch by option
// - Port write loads six latches, two spare bits
// - Power bit 7 enables watchdog, resets set
// - Power bit 6 routes pin zero to interrupt
// - Power bits 5,3,2 enable detector, reset, comparator
// - Six wake bits enable pin wake, reset set
// - PC high buffer two bits, bit 2 spare
// - Pull-down bits active low, reset disabled
// - Pull-up bits active low, reset disabled
// - Enable bits mask individual interrupt sources
// - Tick0 overflow flag sticky until software clears
// - Pin change flag cleared only by software
// - Flag reads zero while its enable clear
// - Global enable gates all interrupt requests
module core_sfr_status_port_irq_bank (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    input wire logic alu_update,
    input wire logic alu_carry,
    input wire logic alu_half_carry,
    input wire logic logic_update,
    input wire logic [7:0] logic_result,
    input wire logic sleep_exec,
    input wire logic clrwdt_exec,
    input wire logic watchdog_timeout,
    input wire logic tick0_overflow,
    input wire logic tick1_underflow,
    input wire logic lowv_event,
    input wire logic watchdog_irq_event,
    input wire logic ext_edge_rising,
    input wire logic global_irq_enable,
    input wire logic pin_readback_option,
    input wire logic [5:0] port_dir_input,
    input wire logic [5:0] port_pin_in,
    output logic [5:0] port_out,
    output logic [5:0] indirect_addr,
    output logic watchdog_enable,
    output logic ext_irq_pin_select,
    output logic lowv_detect_enable,
    output logic lowv_reset_enable,
    output logic comparator_enable,
    output logic [5:0] pin_wake_enable,
    output logic [3:0] pulldown_off_n,
    output logic [5:0] pullup_off_n,
    output logic [1:0] pc_high_latch,
    output logic irq_req,
    output logic wake_req
);

    // ==========================================================
    // State
    sfr_bank_pkg::bank_state_t st_r;
    sfr_bank_pkg::bank_state_t st_nxt;

    logic [7:0] flag_view;
    logic [7:0] port_view;
    logic [5:0] pin_change;
    logic ext_edge;
    logic sync_ready;
    logic [7:0] events;

    // Pin zero edge and input change both look only at the settled second stage
    always_comb begin
        sync_ready = (st_r.sync_fill == sfr_bank_pkg::SYNC_FILLED);
        // No edge until the history holds a real sample, so a pin idling high after reset is no event
        pin_change = (st_r.pin_s2 ^ st_r.pin_prev) & port_dir_input & {6{sync_ready}};
        ext_edge = ext_edge_rising ? (st_r.pin_s2[0] & ~st_r.pin_prev[0])
                                   : (~st_r.pin_s2[0] & st_r.pin_prev[0]);
        ext_edge = ext_edge & sync_ready;
        events = 8'h00;
        events[sfr_bank_pkg::IRQ_TICK0] = tick0_overflow;
        events[sfr_bank_pkg::IRQ_PIN_CHANGE] = |pin_change;
        // External source only counts while pin zero is routed to it
        events[sfr_bank_pkg::IRQ_EXT] = ext_edge & st_r.power[sfr_bank_pkg::POW_EXT_SEL];
        events[sfr_bank_pkg::IRQ_TICK1] = tick1_underflow;
        events[sfr_bank_pkg::IRQ_LOWV] = lowv_event;
        events[sfr_bank_pkg::IRQ_WATCHDOG] = watchdog_irq_event;
        flag_view = st_r.irq_flag & st_r.irq_en & sfr_bank_pkg::IRQ_IMPL_MASK;
        // Output pins read back the pin or the latch, picked by the option strap
        for (int i = 0; i < 6; i++) begin
            if (port_dir_input[i] || !pin_readback_option) begin
                port_view[i] = st_r.pin_s2[i];
            end else begin
                port_view[i] = st_r.port_latch[i];
            end
        end
        port_view[7:6] = st_r.port_spare;
    end

    // ==========================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.pin_s1 = port_pin_in;
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.pin_prev = st_r.pin_s2;
        if (st_r.sync_fill != sfr_bank_pkg::SYNC_FILLED) begin
            st_nxt.sync_fill = st_r.sync_fill + 2'h1;
        end
        // Software writes first; hardware events below override them
        if (reg_wr_en) begin
            case (reg_addr)
                sfr_bank_pkg::OFS_STATUS: begin
                    st_nxt.status_spare = reg_wr_data[7:5];
                    st_nxt.watchdog_expiry_flag_n = reg_wr_data[4];
                    st_nxt.powerdown_flag_n = reg_wr_data[3];
                    st_nxt.zero = reg_wr_data[2];
                    st_nxt.half_carry = reg_wr_data[1];
                    st_nxt.carry = reg_wr_data[0];
                end
                sfr_bank_pkg::OFS_POINTER: begin
                    // Bank bits are stored as written; software keeps them at zero
                    st_nxt.pointer = reg_wr_data;
                end
                sfr_bank_pkg::OFS_PORT: begin
                    st_nxt.port_latch = reg_wr_data[5:0];
                    st_nxt.port_spare = reg_wr_data[7:6];
                end
                sfr_bank_pkg::OFS_POWER: begin
                    st_nxt.power = reg_wr_data;
                end
                sfr_bank_pkg::OFS_WAKE: begin
                    st_nxt.wake = reg_wr_data[5:0];
                end
                sfr_bank_pkg::OFS_PCHI: begin
                    st_nxt.pc_high = reg_wr_data[2:0];
                end
                sfr_bank_pkg::OFS_PULLDN: begin
                    st_nxt.pulldown_off_n = reg_wr_data[7:4];
                end
                sfr_bank_pkg::OFS_PULLUP: begin
                    st_nxt.pullup_off_n = reg_wr_data[5:0];
                end
                sfr_bank_pkg::OFS_IRQ_EN: begin
                    st_nxt.irq_en = reg_wr_data & sfr_bank_pkg::IRQ_IMPL_MASK;
                end
                sfr_bank_pkg::OFS_IRQ_FLAG: begin
                    st_nxt.irq_flag = reg_wr_data & sfr_bank_pkg::IRQ_IMPL_MASK;
                end
                default: begin
                end
            endcase
        end
        // Arithmetic results win over a same-cycle write of the status byte
        if (alu_update) begin
            st_nxt.carry = alu_carry;
            st_nxt.half_carry = alu_half_carry;
        end
        if (logic_update) begin
            st_nxt.zero = (logic_result == 8'h00);
        end
        if (clrwdt_exec) begin
            st_nxt.powerdown_flag_n = 1'b1;
            st_nxt.watchdog_expiry_flag_n = 1'b1;
        end
        if (sleep_exec) begin
            st_nxt.powerdown_flag_n = 1'b0;
            st_nxt.watchdog_expiry_flag_n = 1'b1;
        end
        if (watchdog_timeout) begin
            st_nxt.watchdog_expiry_flag_n = 1'b0;
        end
        // Set beats clear, so an event landing on a clearing write is kept
        st_nxt.irq_flag = st_nxt.irq_flag | events;
        st_nxt.irq_req = global_irq_enable & |(st_nxt.irq_flag & st_nxt.irq_en);
        st_nxt.wake_req = |(pin_change & st_r.wake);
        st_nxt.rd_data = 8'h00;
        if (reg_rd_en) begin
            case (reg_addr)
                sfr_bank_pkg::OFS_STATUS: begin
                    st_nxt.rd_data = {st_r.status_spare, st_r.watchdog_expiry_flag_n,
                                      st_r.powerdown_flag_n, st_r.zero, st_r.half_carry, st_r.carry};
                end
                sfr_bank_pkg::OFS_POINTER: begin
                    st_nxt.rd_data = st_r.pointer;
                end
                sfr_bank_pkg::OFS_PORT: begin
                    st_nxt.rd_data = port_view;
                end
                sfr_bank_pkg::OFS_POWER: begin
                    st_nxt.rd_data = st_r.power;
                end
                sfr_bank_pkg::OFS_WAKE: begin
                    st_nxt.rd_data = {2'h0, st_r.wake};
                end
                sfr_bank_pkg::OFS_PCHI: begin
                    st_nxt.rd_data = {5'h00, st_r.pc_high};
                end
                sfr_bank_pkg::OFS_PULLDN: begin
                    st_nxt.rd_data = {st_r.pulldown_off_n, 4'h0};
                end
                sfr_bank_pkg::OFS_PULLUP: begin
                    st_nxt.rd_data = {2'h0, st_r.pullup_off_n};
                end
                sfr_bank_pkg::OFS_IRQ_EN: begin
                    st_nxt.rd_data = st_r.irq_en;
                end
                sfr_bank_pkg::OFS_IRQ_FLAG: begin
                    st_nxt.rd_data = flag_view;
                end
                default: begin
                    st_nxt.rd_data = 8'h00;
                end
            endcase
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
            st_r.watchdog_expiry_flag_n <= 1'b1;
            st_r.powerdown_flag_n <= 1'b1;
            st_r.pointer <= sfr_bank_pkg::POINTER_RESET;
            st_r.power <= sfr_bank_pkg::POWER_RESET;
            st_r.wake <= sfr_bank_pkg::WAKE_RESET;
            st_r.pc_high <= sfr_bank_pkg::PCHI_RESET;
            st_r.pulldown_off_n <= sfr_bank_pkg::PULLDN_RESET;
            st_r.pullup_off_n <= sfr_bank_pkg::PULLUP_RESET;
            st_r.irq_en <= sfr_bank_pkg::IRQ_RESET;
            st_r.irq_flag <= sfr_bank_pkg::IRQ_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rd_data = st_r.rd_data;
    assign port_out = st_r.port_latch;
    assign indirect_addr = st_r.pointer[5:0];
    assign watchdog_enable = st_r.power[sfr_bank_pkg::POW_WATCHDOG];
    assign ext_irq_pin_select = st_r.power[sfr_bank_pkg::POW_EXT_SEL];
    assign lowv_detect_enable = st_r.power[sfr_bank_pkg::POW_LOWV_DET];
    assign lowv_reset_enable = st_r.power[sfr_bank_pkg::POW_LOWV_RST];
    assign comparator_enable = st_r.power[sfr_bank_pkg::POW_COMPARATOR];
    assign pin_wake_enable = st_r.wake;
    assign pulldown_off_n = st_r.pulldown_off_n;
    assign pullup_off_n = st_r.pullup_off_n;
    assign pc_high_latch = st_r.pc_high[1:0];
    assign irq_req = st_r.irq_req;
    assign wake_req = st_r.wake_req;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    property p_carry;
        alu_update |=> (st_r.carry == $past(alu_carry)) && (st_r.half_carry == $past(alu_half_carry));
    endproperty
    a_carry: assert property (p_carry) else $error("carry flags not loaded from alu");

    property p_zero;
        logic_update && logic_result == 8'h00 |=> st_r.zero;
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag not set on zero result");

    property p_sleep;
        sleep_exec && !watchdog_timeout |=> !st_r.powerdown_flag_n && st_r.watchdog_expiry_flag_n;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep did not mark power-down");

    property p_expiry;
        watchdog_timeout |=> !st_r.watchdog_expiry_flag_n;
    endproperty
    a_expiry: assert property (p_expiry) else $error("timeout did not clear expiry flag");

    property p_tick0_sticky;
        st_r.irq_flag[0] && !(reg_wr_en && reg_addr == sfr_bank_pkg::OFS_IRQ_FLAG) |=> st_r.irq_flag[0];
    endproperty
    a_tick0_sticky: assert property (p_tick0_sticky) else $error("tick0 flag lost without write");

    property p_set_wins;
        tick0_overflow ##0 reg_wr_en && reg_addr == sfr_bank_pkg::OFS_IRQ_FLAG |=> st_r.irq_flag[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost against clear");

    property p_masked_read;
        reg_rd_en && reg_addr == sfr_bank_pkg::OFS_IRQ_FLAG && !st_r.irq_en[1] |=> reg_rd_data[1] == 1'b0;
    endproperty
    a_masked_read: assert property (p_masked_read) else $error("masked flag read nonzero");

    property p_irq;
        irq_req == ($past(global_irq_enable) && (|(st_r.irq_flag & st_r.irq_en)));
    endproperty
    a_irq: assert property (p_irq) else $error("request not gated by global enable");

    property p_unmapped;
        reg_rd_en && (reg_addr == 4'h5 || reg_addr == 4'hD) |=> reg_rd_data == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_port_in;
        reg_rd_en && reg_addr == sfr_bank_pkg::OFS_PORT && port_dir_input[3]
            |=> reg_rd_data[3] == $past(st_r.pin_s2[3]);
    endproperty
    a_port_in: assert property (p_port_in) else $error("input pin readback wrong");

    property p_pointer_write;
        reg_wr_en && reg_addr == sfr_bank_pkg::OFS_POINTER |=> indirect_addr == $past(reg_wr_data[5:0]);
    endproperty
    a_pointer_write: assert property (p_pointer_write) else $error("pointer write not seen");

    property p_port_write;
        reg_wr_en && reg_addr == sfr_bank_pkg::OFS_PORT |=> port_out == $past(reg_wr_data[5:0]);
    endproperty
    a_port_write: assert property (p_port_write) else $error("port latch write not seen");

    property p_power_write;
        reg_wr_en && reg_addr == sfr_bank_pkg::OFS_POWER
            |=> watchdog_enable == $past(reg_wr_data[sfr_bank_pkg::POW_WATCHDOG])
                && lowv_detect_enable == $past(reg_wr_data[sfr_bank_pkg::POW_LOWV_DET])
                && comparator_enable == $past(reg_wr_data[sfr_bank_pkg::POW_COMPARATOR]);
    endproperty
    a_power_write: assert property (p_power_write) else $error("power enables not loaded");

    property p_ext_gated;
        !st_r.power[sfr_bank_pkg::POW_EXT_SEL] && !st_r.irq_flag[sfr_bank_pkg::IRQ_EXT]
            && !(reg_wr_en && reg_addr == sfr_bank_pkg::OFS_IRQ_FLAG) |=> !st_r.irq_flag[sfr_bank_pkg::IRQ_EXT];
    endproperty
    a_ext_gated: assert property (p_ext_gated) else $error("external flag set while pin unrouted");

    property p_wake_write;
        reg_wr_en && reg_addr == sfr_bank_pkg::OFS_WAKE |=> pin_wake_enable == $past(reg_wr_data[5:0]);
    endproperty
    a_wake_write: assert property (p_wake_write) else $error("wake enables not loaded");

    property p_pchi_write;
        reg_wr_en && reg_addr == sfr_bank_pkg::OFS_PCHI |=> pc_high_latch == $past(reg_wr_data[1:0]);
    endproperty
    a_pchi_write: assert property (p_pchi_write) else $error("pc high buffer not loaded");

    property p_pulldown_write;
        reg_wr_en && reg_addr == sfr_bank_pkg::OFS_PULLDN |=> pulldown_off_n == $past(reg_wr_data[7:4]);
    endproperty
    a_pulldown_write: assert property (p_pulldown_write) else $error("pull-down controls not loaded");

    property p_pullup_write;
        reg_wr_en && reg_addr == sfr_bank_pkg::OFS_PULLUP |=> pullup_off_n == $past(reg_wr_data[5:0]);
    endproperty
    a_pullup_write: assert property (p_pullup_write) else $error("pull-up controls not loaded");

    property p_irq_en_write;
        reg_wr_en && reg_addr == sfr_bank_pkg::OFS_IRQ_EN
            |=> st_r.irq_en == ($past(reg_wr_data) & sfr_bank_pkg::IRQ_IMPL_MASK);
    endproperty
    a_irq_en_write: assert property (p_irq_en_write) else $error("enable mask not loaded");

    property p_pin_change_sticky;
        st_r.irq_flag[1] && !(reg_wr_en && reg_addr == sfr_bank_pkg::OFS_IRQ_FLAG) |=> st_r.irq_flag[1];
    endproperty
    a_pin_change_sticky: assert property (p_pin_change_sticky) else $error("pin change flag lost");

    c_irq: cover property (global_irq_enable && tick0_overflow ##1 irq_req);
    c_sleep_wake: cover property (sleep_exec ##[1:20] wake_req);
    c_clear_race: cover property (tick0_overflow && reg_wr_en && reg_addr == sfr_bank_pkg::OFS_IRQ_FLAG);
    c_port_read: cover property (reg_rd_en && reg_addr == sfr_bank_pkg::OFS_PORT);
    c_ext_event: cover property (ext_edge && st_r.power[sfr_bank_pkg::POW_EXT_SEL]);

endmodule : core_sfr_status_port_irq_bank

// ---- sim/pin_pad_model.sv ----
// Pad-side model of the six port pins seen by the register bank
module pin_pad_model (
    input wire logic [5:0] port_out,
    input wire logic [5:0] port_dir_input,
    input wire logic [5:0] ext_level,
    input wire logic load_short,
    output logic [5:0] port_pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Pad level
    // An overloaded output follows the outside level, so pin and latch readback differ
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            port_pin_in[i] = (port_dir_input[i] | load_short) ? ext_level[i] : port_out[i];
        end
    end
endmodule : pin_pad_model

// ---- sim/test_core_sfr_status_port_irq_bank.sv ----
// Self-checking bench for the special-function register bank
module test_core_sfr_status_port_irq_bank;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // Stimulus and observed signals
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wr_data = 8'h00;
    logic [7:0] logic_result = 8'h00;
    logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, alu_carry = 1'b0, alu_half_carry = 1'b0;
    logic alu_update = 1'b0, logic_update = 1'b0, sleep_exec = 1'b0, clrwdt_exec = 1'b0, watchdog_timeout = 1'b0;
    logic tick0_overflow = 1'b0, tick1_underflow = 1'b0, lowv_event = 1'b0, watchdog_irq_event = 1'b0;
    logic ext_edge_rising = 1'b1, global_irq_enable = 1'b0, pin_readback_option = 1'b0, load_short = 1'b0;
    logic [5:0] port_dir_input = 6'h3F;
    logic [5:0] ext_level = 6'h00;
    logic [7:0] reg_rd_data;
    logic [5:0] port_pin_in, port_out, indirect_addr, pin_wake_enable, pullup_off_n;
    logic [3:0] pulldown_off_n;
    logic [1:0] pc_high_latch;
    logic watchdog_enable, ext_irq_pin_select, lowv_detect_enable, lowv_reset_enable, comparator_enable;
    logic irq_req, wake_req;
    int err_count = 0;
    int num_checks = 0;
    localparam logic [3:0] ADDRS [10] = '{4'h3, 4'h4, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hE, 4'hF};
    localparam logic [7:0] RSTV [10] = '{8'h18, 8'h00, 8'h00, 8'h88, 8'h3F, 8'h00, 8'hF0, 8'h3F, 8'h00, 8'h00};
    localparam logic [7:0] MASKS [10] = '{8'hFF, 8'h3F, 8'hC0, 8'hFF, 8'h3F, 8'h07, 8'hF0, 8'h3F, 8'h5F, 8'h5F};
    localparam logic [3:0] UNMAP [6] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h7, 4'hD};
    localparam int BITS [6] = '{0, 1, 2, 3, 4, 6};

    always #10 sys_clk = ~sys_clk;

    core_sfr_status_port_irq_bank dut (.*);
    pin_pad_model pads (.*);

    // ==========================================================
    // Bus cycles and comparison
    task tick;
        @(posedge sys_clk);
        #1;
    endtask : tick

    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // An idle cycle follows each access so no strobe is assigned twice at one instant
    task wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        tick;
        reg_wr_en = 1'b0;
        tick;
    endtask : wr

    task rd_chk(input logic [3:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd_en = 1'b1;
        tick;
        reg_rd_en = 1'b0;
        chk(reg_rd_data, exp);
        tick;
    endtask : rd_chk

    // One-cycle pulse on a core event line, index 8 down to 0
    task pulse(input int k);
        {alu_update, logic_update, sleep_exec, clrwdt_exec, watchdog_timeout, tick0_overflow,
         tick1_underflow, lowv_event, watchdog_irq_event} = 9'h001 << k;
        tick;
        {alu_update, logic_update, sleep_exec, clrwdt_exec, watchdog_timeout, tick0_overflow,
         tick1_underflow, lowv_event, watchdog_irq_event} = 9'h000;
        tick;
    endtask : pulse

    // ==========================================================
    // Scenarios
    task t_reset;
        for (int i = 0; i < 10; i++) rd_chk(ADDRS[i], RSTV[i]);
        chk({3'h0, watchdog_enable, ext_irq_pin_select, lowv_detect_enable, lowv_reset_enable, comparator_enable},
            8'h12);
        chk({pin_wake_enable, pc_high_latch}, 8'hFC);
        chk({pulldown_off_n, irq_req, 3'h0}, 8'hF0);
        chk({2'h0, pullup_off_n}, 8'h3F);
        chk({port_out, indirect_addr[1:0]}, 8'h00);
        $display("t_reset done");
    endtask : t_reset

    task t_rw;
        logic [7:0] v;
        for (int p = 0; p < 3; p++) begin
            v = (p == 0) ? 8'hFF : ((p == 1) ? 8'h5A : 8'h00);
            // Software keeps the bank select bits of the pointer at zero
            for (int i = 0; i < 10; i++) wr(ADDRS[i], (i == 1) ? (v & 8'h3F) : v);
            for (int i = 0; i < 10; i++) rd_chk(ADDRS[i], v & MASKS[i]);
            chk({3'h0, watchdog_enable, ext_irq_pin_select, lowv_detect_enable, lowv_reset_enable, comparator_enable},
                {3'h0, v[7:5], v[3:2]});
            chk({port_out, 2'h0}, {v[5:0], 2'h0});
            chk({2'h0, indirect_addr}, {2'h0, v[5:0]});
            chk({pin_wake_enable, pc_high_latch}, {v[5:0], v[1:0]});
            chk({pulldown_off_n, 4'h0}, {v[7:4], 4'h0});
            chk({2'h0, pullup_off_n}, {2'h0, v[5:0]});
        end
        for (int i = 0; i < 6; i++) begin
            wr(UNMAP[i], 8'hFF);
            rd_chk(UNMAP[i], 8'h00);
        end
        $display("t_rw done");
    endtask : t_rw

    task t_alu;
        wr(4'h3, 8'h00);
        for (int i = 0; i < 4; i++) begin
            alu_carry = i[0];
            alu_half_carry = i[1];
            pulse(8);
            rd_chk(4'h3, {6'h0, i[1], i[0]});
        end
        logic_result = 8'h00;
        pulse(7);
        rd_chk(4'h3, 8'h07);
        logic_result = 8'h80;
        pulse(7);
        rd_chk(4'h3, 8'h03);
        pulse(6);
        rd_chk(4'h3, 8'h13);
        pulse(5);
        rd_chk(4'h3, 8'h1B);
        pulse(4);
        rd_chk(4'h3, 8'h0B);
        $display("t_alu done");
    endtask : t_alu

    task t_port;
        port_dir_input = 6'h0F;
        wr(4'h6, 8'hFF);
        ext_level = 6'h05;
        load_short = 1'b1;
        pin_readback_option = 1'b1;
        repeat (4) tick;
        rd_chk(4'h6, 8'hF5);
        pin_readback_option = 1'b0;
        rd_chk(4'h6, 8'hC5);
        load_short = 1'b0;
        repeat (4) tick;
        rd_chk(4'h6, 8'hF5);
        port_dir_input = 6'h3F;
        ext_level = 6'h00;
        repeat (4) tick;
        $display("t_port done");
    endtask : t_port

    // Each source in turn: raise, mask, gate globally, then clear by software
    task t_irq;
        int b;
        logic [7:0] m;
        wr(4'h8, 8'hC8);
        wr(4'hF, 8'h00);
        for (int j = 0; j < 6; j++) begin
            b = BITS[j];
            m = 8'h01 << b;
            wr(4'hE, m);
            global_irq_enable = 1'b1;
            case (b)
                0: pulse(3);
                1: begin
                    ext_level[1] = 1'b1;
                    repeat (3) tick;
                    chk({7'h0, wake_req}, 8'h01);
                    tick;
                    chk({7'h0, wake_req}, 8'h00);
                end
                2: ext_level[0] = 1'b1;
                3: pulse(2);
                4: pulse(1);
                default: pulse(0);
            endcase
            repeat (4) tick;
            chk({7'h0, irq_req}, 8'h01);
            rd_chk(4'hF, m);
            wr(4'hE, 8'h00);
            chk({7'h0, irq_req}, 8'h00);
            rd_chk(4'hF, 8'h00);
            wr(4'hE, m);
            global_irq_enable = 1'b0;
            tick;
            chk({7'h0, irq_req}, 8'h00);
            global_irq_enable = 1'b1;
            tick;
            chk({7'h0, irq_req}, 8'h01);
            wr(4'hF, 8'h00);
            chk({7'h0, irq_req}, 8'h00);
            rd_chk(4'hF, 8'h00);
            ext_level = 6'h00;
            global_irq_enable = 1'b0;
            repeat (4) tick;
            wr(4'hF, 8'h00);
        end
        $display("t_irq done");
    endtask : t_irq

    // ==========================================================
    // Run control
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (3) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        t_reset;
        t_rw;
        nrst = 1'b0;
        repeat (3) tick;
        nrst = 1'b1;
        t_reset;
        t_alu;
        t_port;
        t_irq;
        finish_test;
    end

    // The whole run needs about 420 cycles; this limit leaves wide margin
    initial begin
        #400us;
        err_count++;
        $display("FAIL %0t watchdog expired", $time);
        finish_test;
    end
endmodule : test_core_sfr_status_port_irq_bank
